// [verilog/uafs_pkg.sv]
// package: register map, field positions, reset values and timing for the serial frame block
package uafs_pkg;
  // register byte offsets
  localparam logic [7:0] UAFS_OFF_MODE = 8'h00;
  localparam logic [7:0] UAFS_OFF_STAT = 8'h04;
  localparam logic [7:0] UAFS_OFF_ISTS = 8'h08;
  localparam logic [7:0] UAFS_OFF_IMSK = 8'h0C;
  localparam logic [7:0] UAFS_OFF_DIV = 8'h10;
  localparam logic [7:0] UAFS_OFF_TXD = 8'h14;
  // serial_mode_control fields
  localparam int UAFS_MODE_IRENC = 12;
  localparam int UAFS_MODE_HSPEED = 3;
  localparam int UAFS_MODE_DPS_LO = 1;
  localparam int UAFS_MODE_STOP = 0;
  localparam logic [15:0] UAFS_MODE_RST = 16'h0000;
  // serial_status_control fields
  localparam int UAFS_STAT_TXIM1 = 15;
  localparam int UAFS_STAT_INV = 14;
  localparam int UAFS_STAT_TXIM0 = 13;
  localparam int UAFS_STAT_BRK = 11;
  localparam int UAFS_STAT_EN = 10;
  localparam int UAFS_STAT_BFULL = 9;
  localparam int UAFS_STAT_SEMPTY = 8;
  localparam int UAFS_STAT_RXIM_LO = 6;
  localparam int UAFS_STAT_ADDEN = 5;
  localparam int UAFS_STAT_RIDLE = 4;
  // interrupt status / mask fields
  localparam int UAFS_INT_LOAD = 0;
  localparam int UAFS_INT_DONE = 1;
  localparam logic [1:0] UAFS_INT_RST = 2'h0;
  localparam logic [15:0] UAFS_DIV_RST = 16'h0000;
  // last rate phase index per bit period (the rate multiple minus one)
  localparam logic [3:0] UAFS_MULT_HS = 4'h3;
  localparam logic [3:0] UAFS_MULT_STD = 4'hF;
  // data/parity selections
  typedef enum logic [1:0] {
    UAFS_DP_8N = 2'b00,
    UAFS_DP_8E = 2'b01,
    UAFS_DP_8O = 2'b10,
    UAFS_DP_9N = 2'b11
  } uafs_dps_t;
  typedef enum logic [2:0] {
    UAFS_TX_IDLE = 3'b000,
    UAFS_TX_START = 3'b001,
    UAFS_TX_DATA = 3'b010,
    UAFS_TX_PAR = 3'b011,
    UAFS_TX_STOP = 3'b100
  } uafs_txst_t;
endpackage

// [verilog/uafs_rate_if.sv]
// interface: link between the transmitter and its bit-rate generator
`timescale 1ns/1ps
interface uafs_rate_if;
  logic [15:0] divisor;
  logic high_speed_rate_select;
  logic run;
  logic bit_tick;
  modport gen (input divisor, input high_speed_rate_select, input run, output bit_tick);
  modport user (output divisor, output high_speed_rate_select, output run, input bit_tick);
endinterface

// [verilog/uafs_rate_generator.sv]
// module: rate generator, one pulse per serial bit period
`timescale 1ns/1ps
module uafs_rate_generator
  import uafs_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // transmitter side
  uafs_rate_if.gen rif
);
  logic [15:0] div_cnt_q, div_cnt_d;
  logic [3:0] phase_q, phase_d;
  logic tick_q, tick_d;
  logic [3:0] last_phase;

  always_comb begin
    last_phase = rif.high_speed_rate_select ? UAFS_MULT_HS : UAFS_MULT_STD;
    div_cnt_d = div_cnt_q;
    phase_d = phase_q;
    tick_d = 1'b0;
    // restart while idle so a frame always begins on a whole bit period
    if (!rif.run) begin
      div_cnt_d = rif.divisor;
      phase_d = 4'h0;
    end else if (div_cnt_q == 16'h0000) begin
      div_cnt_d = rif.divisor;
      if (phase_q >= last_phase) begin
        phase_d = 4'h0;
        tick_d = 1'b1;
      end else begin
        phase_d = phase_q + 4'h1;
      end
    end else begin
      div_cnt_d = div_cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= UAFS_DIV_RST;
      phase_q <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      phase_q <= phase_d;
      tick_q <= tick_d;
    end
  end

  assign rif.bit_tick = tick_q;
endmodule

// [verilog/uafs_serial_port.sv]
// module: serial port frame format, status/control registers and transmitter, APB slave
// Functional notes
// - With the high-speed option set, a bit period is four divisor periods of the rate generator.
// - With the high-speed option clear, a bit period is sixteen divisor periods of the rate generator.
// - Data/parity select 11 sends nine data bits and no parity bit.
// - Data/parity select 10, 01, 00 sends eight data bits with odd, even or no parity.
// - Stop-count select set ends each character with two stop bits, clear with one.
// - With infrared encoding off, polarity invert set idles the line low, clear idles it high.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module uafs_serial_port
  import uafs_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial line and interrupt
  output logic serial_transmit_line,
  output logic irq
);
  uafs_rate_if rif ();

  // register state
  logic [15:0] mode_q, mode_d;
  logic [1:0] txim_q, txim_d;
  logic [1:0] rxim_q, rxim_d;
  logic inv_q, inv_d, brk_q, brk_d, en_q, en_d, adden_q, adden_d;
  logic [1:0] ists_q, ists_d, imsk_q, imsk_d;
  logic [15:0] div_q, div_d;
  logic [31:0] prdata_q, prdata_d;
  // transmitter state
  uafs_txst_t st_q, st_d;
  logic [8:0] buf_q, buf_d, sh_q, sh_d;
  logic bfull_q, bfull_d;
  logic [3:0] cnt_q, cnt_d;
  logic par_q, par_d, stop2nd_q, stop2nd_d, line_q, line_d;
  logic ev_load, ev_done, raw;
  logic wr_en, setup;
  uafs_dps_t dps;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == UAFS_OFF_MODE) || (a == UAFS_OFF_STAT) || (a == UAFS_OFF_ISTS) ||
              (a == UAFS_OFF_IMSK) || (a == UAFS_OFF_DIV) || (a == UAFS_OFF_TXD);
  endfunction

  function automatic logic [15:0] stat_word(input logic [1:0] txim, input logic inv,
                                            input logic brk, input logic en,
                                            input logic bfull, input logic sempty,
                                            input logic [1:0] rxim, input logic adden);
    stat_word = 16'h0000;
    stat_word[UAFS_STAT_TXIM1] = txim[1];
    stat_word[UAFS_STAT_INV] = inv;
    stat_word[UAFS_STAT_TXIM0] = txim[0];
    stat_word[UAFS_STAT_BRK] = brk;
    stat_word[UAFS_STAT_EN] = en;
    stat_word[UAFS_STAT_BFULL] = bfull;
    stat_word[UAFS_STAT_SEMPTY] = sempty;
    stat_word[UAFS_STAT_RXIM_LO +: 2] = rxim;
    stat_word[UAFS_STAT_ADDEN] = adden;
    // receiver is not built: it always reads idle with no errors
    stat_word[UAFS_STAT_RIDLE] = 1'b1;
  endfunction

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && addr_ok(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok(paddr);
  assign prdata = prdata_q;
  assign dps = uafs_dps_t'(mode_q[UAFS_MODE_DPS_LO +: 2]);

  // register file
  always_comb begin
    mode_d = mode_q;
    txim_d = txim_q;
    rxim_d = rxim_q;
    inv_d = inv_q;
    brk_d = brk_q;
    en_d = en_q;
    adden_d = adden_q;
    imsk_d = imsk_q;
    div_d = div_q;
    ists_d = ists_q;
    prdata_d = prdata_q;
    // read data is captured in the setup phase so the access phase needs no wait
    if (setup) begin
      unique case (paddr)
        UAFS_OFF_MODE: prdata_d = {16'h0000, mode_q};
        UAFS_OFF_STAT: prdata_d = {16'h0000, stat_word(txim_q, inv_q, brk_q, en_q, bfull_q,
                                   (st_q == UAFS_TX_IDLE) && !bfull_q, rxim_q, adden_q)};
        UAFS_OFF_ISTS: prdata_d = {30'h0, ists_q};
        UAFS_OFF_IMSK: prdata_d = {30'h0, imsk_q};
        UAFS_OFF_DIV: prdata_d = {16'h0000, div_q};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
    if (wr_en) begin
      unique case (paddr)
        UAFS_OFF_MODE: mode_d = pwdata[15:0];
        UAFS_OFF_STAT: begin
          txim_d = {pwdata[UAFS_STAT_TXIM1], pwdata[UAFS_STAT_TXIM0]};
          inv_d = pwdata[UAFS_STAT_INV];
          brk_d = pwdata[UAFS_STAT_BRK];
          en_d = pwdata[UAFS_STAT_EN];
          rxim_d = pwdata[UAFS_STAT_RXIM_LO +: 2];
          adden_d = pwdata[UAFS_STAT_ADDEN];
        end
        UAFS_OFF_ISTS: ists_d = ists_q & ~pwdata[1:0];
        UAFS_OFF_IMSK: imsk_d = pwdata[1:0];
        UAFS_OFF_DIV: div_d = pwdata[15:0];
        default: ;
      endcase
    end
    // a new event outranks a clear written in the same cycle
    ists_d[UAFS_INT_LOAD] = ists_d[UAFS_INT_LOAD] | ev_load;
    ists_d[UAFS_INT_DONE] = ists_d[UAFS_INT_DONE] | ev_done;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= UAFS_MODE_RST;
      txim_q <= 2'h0;
      rxim_q <= 2'h0;
      inv_q <= 1'b0;
      brk_q <= 1'b0;
      en_q <= 1'b0;
      adden_q <= 1'b0;
      ists_q <= UAFS_INT_RST;
      imsk_q <= UAFS_INT_RST;
      div_q <= UAFS_DIV_RST;
      prdata_q <= 32'h0000_0000;
    end else begin
      mode_q <= mode_d;
      txim_q <= txim_d;
      rxim_q <= rxim_d;
      inv_q <= inv_d;
      brk_q <= brk_d;
      en_q <= en_d;
      adden_q <= adden_d;
      ists_q <= ists_d;
      imsk_q <= imsk_d;
      div_q <= div_d;
      prdata_q <= prdata_d;
    end
  end

  assign irq = |(ists_q & imsk_q);

  // rate generator hookup
  assign rif.divisor = div_q;
  assign rif.high_speed_rate_select = mode_q[UAFS_MODE_HSPEED];
  assign rif.run = (st_q != UAFS_TX_IDLE);

  uafs_rate_generator u_rate (
    .pclk(pclk),
    .presetn(presetn),
    .rif(rif)
  );

  // transmitter
  always_comb begin
    st_d = st_q;
    buf_d = buf_q;
    bfull_d = bfull_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    par_d = par_q;
    stop2nd_d = stop2nd_q;
    ev_load = 1'b0;
    ev_done = 1'b0;
    raw = 1'b1;
    // a full holding buffer ignores further data writes
    if (wr_en && (paddr == UAFS_OFF_TXD) && en_q && !bfull_q) begin
      buf_d = pwdata[8:0];
      bfull_d = 1'b1;
    end
    unique case (st_q)
      UAFS_TX_IDLE: begin
        if (bfull_q && en_q) begin
          sh_d = (dps == UAFS_DP_9N) ? buf_q : {1'b0, buf_q[7:0]};
          par_d = (dps == UAFS_DP_8O) ? ~^buf_q[7:0] : ^buf_q[7:0];
          bfull_d = 1'b0;
          cnt_d = 4'h0;
          stop2nd_d = 1'b0;
          ev_load = 1'b1;
          st_d = UAFS_TX_START;
        end
      end
      UAFS_TX_START: begin
        raw = 1'b0;
        if (rif.bit_tick) begin
          st_d = UAFS_TX_DATA;
        end
      end
      UAFS_TX_DATA: begin
        raw = sh_q[0];
        if (rif.bit_tick) begin
          sh_d = {1'b0, sh_q[8:1]};
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == ((dps == UAFS_DP_9N) ? 4'h8 : 4'h7)) begin
            st_d = ((dps == UAFS_DP_8E) || (dps == UAFS_DP_8O)) ? UAFS_TX_PAR
                                                                : UAFS_TX_STOP;
          end
        end
      end
      UAFS_TX_PAR: begin
        raw = par_q;
        if (rif.bit_tick) begin
          st_d = UAFS_TX_STOP;
        end
      end
      UAFS_TX_STOP: begin
        raw = 1'b1;
        if (rif.bit_tick) begin
          if (mode_q[UAFS_MODE_STOP] && !stop2nd_q) begin
            stop2nd_d = 1'b1;
          end else begin
            ev_done = 1'b1;
            st_d = UAFS_TX_IDLE;
          end
        end
      end
      default: st_d = UAFS_TX_IDLE;
    endcase
    // disabling aborts the frame and drops any held character
    if (!en_q) begin
      st_d = UAFS_TX_IDLE;
      bfull_d = 1'b0;
    end
    // break forces space; inversion only applies with infrared encoding off
    line_d = (brk_q ? 1'b0 : raw) ^ (inv_q && !mode_q[UAFS_MODE_IRENC]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= UAFS_TX_IDLE;
      buf_q <= 9'h000;
      bfull_q <= 1'b0;
      sh_q <= 9'h000;
      cnt_q <= 4'h0;
      par_q <= 1'b0;
      stop2nd_q <= 1'b0;
      line_q <= 1'b1;
    end else begin
      st_q <= st_d;
      buf_q <= buf_d;
      bfull_q <= bfull_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      par_q <= par_d;
      stop2nd_q <= stop2nd_d;
      line_q <= line_d;
    end
  end

  assign serial_transmit_line = line_q;
endmodule

// [bench/uafs_serial_port_asserts.sv]
// checker: port-level properties of the serial frame block
`timescale 1ns/1ps
module uafs_serial_port_asserts
  import uafs_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // serial line and interrupt
  input wire logic serial_transmit_line,
  input wire logic irq
);
  logic [15:0] mode_q, stat_q, div_q, cnt_q;
  logic [1:0] msk_q, age_q;
  logic line_q, wr, unmapped;
  assign wr = psel && penable && pwrite && pready;
  assign unmapped = paddr > UAFS_OFF_TXD;
  // shadow of written config; age lets the line settle after a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= UAFS_MODE_RST;
      stat_q <= 16'h0000;
      div_q <= UAFS_DIV_RST;
      msk_q <= UAFS_INT_RST;
      age_q <= 2'h3;
      line_q <= 1'b1;
      cnt_q <= 16'h0000;
    end else begin
      line_q <= serial_transmit_line;
      cnt_q <= (serial_transmit_line != line_q) ? 16'h0001 : cnt_q + 16'h0001;
      age_q <= (age_q == 2'h3) ? age_q : age_q + 2'h1;
      if (wr && (paddr == UAFS_OFF_MODE || paddr == UAFS_OFF_STAT)) begin
        age_q <= 2'h0;
      end
      if (wr && paddr == UAFS_OFF_MODE) begin
        mode_q <= pwdata[15:0];
      end
      if (wr && paddr == UAFS_OFF_STAT) begin
        stat_q <= pwdata[15:0];
      end
      if (wr && paddr == UAFS_OFF_DIV) begin
        div_q <= pwdata[15:0];
      end
      if (wr && paddr == UAFS_OFF_IMSK) begin
        msk_q <= pwdata[1:0];
      end
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // end of a low run on a plain line at the undivided rate
  sequence s_low_end;
    !line_q && serial_transmit_line && stat_q[UAFS_STAT_EN] && !stat_q[UAFS_STAT_INV]
      && !stat_q[UAFS_STAT_BRK] && div_q == 16'h0000;
  endsequence
  property p_rate_hs;
    s_low_end ##0 mode_q[UAFS_MODE_HSPEED] |-> cnt_q[1:0] <= 2'h1;
  endproperty
  a_rate_hs: assert property (p_rate_hs) else $error("low run not a multiple of 4");
  property p_rate_std;
    s_low_end ##0 !mode_q[UAFS_MODE_HSPEED] |-> cnt_q[3:0] <= 4'h1;
  endproperty
  a_rate_std: assert property (p_rate_std) else $error("low run not a multiple of 16");
  property p_idle_level;
    age_q == 2'h3 && !stat_q[UAFS_STAT_EN] && !stat_q[UAFS_STAT_BRK]
      |-> serial_transmit_line == (mode_q[UAFS_MODE_IRENC] || !stat_q[UAFS_STAT_INV]);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle level wrong");
  property p_irq_masked;
    msk_q == 2'h0 |-> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq with all masked");
  property p_err;
    psel && penable && paddr[1:0] == 2'h0 |-> pslverr == unmapped;
  endproperty
  a_err: assert property (p_err) else $error("slave error wrong");
  property p_err_data;
    psel && penable && !pwrite && unmapped |-> prdata == 32'h0000_0000;
  endproperty
  a_err_data: assert property (p_err_data) else $error("unmapped read not zero");
endmodule

// [bench/uafs_remote_rx.sv]
// partner: remote receiver decoding frames from the transmit line
`timescale 1ns/1ps
module uafs_remote_rx (
  // clock and line
  input wire logic pclk,
  input wire logic line,
  // expected format
  input var int period,
  input var int nbits,
  input wire logic has_par,
  input var int stops,
  // decoded character
  output logic [8:0] rx_data,
  output logic rx_par,
  output logic rx_stop_ok,
  output int rx_cnt
);
  // samples mid-bit on the falling clock, clear of the launch edge
  initial begin
    rx_cnt = 0;
    forever begin
      @(negedge line);
      rx_data = 9'h000;
      repeat (period / 2 + 1) @(negedge pclk);
      for (int b = 0; b < nbits; b++) begin
        repeat (period) @(negedge pclk);
        rx_data[b] = line;
      end
      if (has_par) begin
        repeat (period) @(negedge pclk);
        rx_par = line;
      end
      rx_stop_ok = 1'b1;
      for (int s = 0; s < stops; s++) begin
        repeat (period) @(negedge pclk);
        rx_stop_ok &= line;
      end
      rx_cnt++;
    end
  end
endmodule

// [bench/uafs_serial_port_tb_top.sv]
// testbench: registers, frame formats, rates, polarity and interrupt
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module uafs_serial_port_tb_top
  import uafs_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, line, irq;
  logic err, par, stop_ok, has_par, pexp;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] rx, dat, msk;
  int err_total, tests_run, period, nbits, stops, rx_cnt, cnt, len, xlen, i;
  logic [3:0] m [9] = '{4'h0, 4'hB, 4'h5, 4'hE, 4'h9, 4'h2, 4'hC, 4'h7, 4'h8};
  logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [31:0] rv [6] = '{32'h0, 32'h110, 32'h0, 32'h0, 32'h0, 32'h0};
  uafs_serial_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_transmit_line(line), .irq(irq));
  uafs_remote_rx u_rx (.pclk(pclk), .line(line), .period(period), .nbits(nbits),
    .has_par(has_par), .stops(stops), .rx_data(rx), .rx_par(par), .rx_stop_ok(stop_ok),
    .rx_cnt(rx_cnt));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only pready ends the access; the watchdog bounds a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    stop_test();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {period, nbits, stops, has_par} = '0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 6; i++) begin
      xfer(ra[i], 1'b0, 32'h0);
      `CHK("reset_value", rv[i], rd)
    end
    xfer(8'h18, 1'b0, 32'h0);
    `CHK("unmapped_err", 1'b1, err)
    `CHK("unmapped_data", 32'h0, rd)
    `CHK("idle_reset", 1'b1, line)
    $display("test reset done");
    xfer(UAFS_OFF_IMSK, 1'b1, 32'h2);
    xfer(UAFS_OFF_STAT, 1'b1, 32'h400);
    xfer(UAFS_OFF_STAT, 1'b0, 32'h0);
    `CHK("stat_rb", 32'h510, rd)
    for (i = 0; i < 9; i++) begin
      // last pass runs the divisor at one, doubling every bit period
      if (i == 8) begin
        xfer(UAFS_OFF_DIV, 1'b1, 32'h1);
        xfer(UAFS_OFF_DIV, 1'b0, 32'h0);
        `CHK("div_rb", 32'h1, rd)
      end
      xfer(UAFS_OFF_MODE, 1'b1, 32'(m[i]));
      xfer(UAFS_OFF_MODE, 1'b0, 32'h0);
      `CHK("mode_rb", 32'(m[i]), rd)
      period = (m[i][3] ? 4 : 16) * ((i == 8) ? 2 : 1);
      nbits = (m[i][2:1] == 2'h3) ? 9 : 8;
      has_par = m[i][2] ^ m[i][1];
      stops = m[i][0] ? 2 : 1;
      msk = (nbits == 9) ? 9'h1FF : 9'h0FF;
      dat = 9'h1A5 ^ 9'(i * 37);
      pexp = (^dat[7:0]) ^ m[i][2];
      cnt = rx_cnt;
      xfer(UAFS_OFF_TXD, 1'b1, {23'h0, dat});
      len = 0;
      while (line !== 1'b0 && len < 200) begin
        @(posedge pclk);
        len++;
      end
      `CHK("start_seen", 1'b1, len < 200)
      `CHK("irq_masked", 1'b0, irq)
      len = 0;
      while (irq !== 1'b1 && len < 1000) begin
        @(posedge pclk);
        len++;
      end
      xlen = (1 + nbits + has_par + stops) * period;
      `CHK("frame_len", 1'b1, len >= xlen && len <= xlen + 3)
      `CHK("data", dat & msk, rx & msk)
      if (has_par) `CHK("parity", pexp, par)
      `CHK("stop", 1'b1, stop_ok)
      `CHK("frames", cnt + 1, rx_cnt)
      xfer(UAFS_OFF_ISTS, 1'b0, 32'h0);
      `CHK("ists", 32'h3, rd)
      // irq is decoded from the status and mask registers: look one edge after the write lands
      xfer(UAFS_OFF_IMSK, 1'b1, 32'h0);
      @(posedge pclk);
      `CHK("irq_mask_off", 1'b0, irq)
      xfer(UAFS_OFF_IMSK, 1'b1, 32'h1);
      @(posedge pclk);
      `CHK("irq_load", 1'b1, irq)
      xfer(UAFS_OFF_IMSK, 1'b1, 32'h2);
      xfer(UAFS_OFF_ISTS, 1'b1, 32'h3);
      @(posedge pclk);
      `CHK("irq_clear", 1'b0, irq)
      xfer(UAFS_OFF_ISTS, 1'b0, 32'h0);
      `CHK("ists_clear", 32'h0, rd)
    end
    $display("test frames done");
    xfer(UAFS_OFF_STAT, 1'b1, 32'h4000);
    repeat (3) @(posedge pclk);
    `CHK("idle_inv", 1'b0, line)
    xfer(UAFS_OFF_MODE, 1'b1, 32'h1000);
    repeat (3) @(posedge pclk);
    `CHK("idle_ir", 1'b1, line)
    $display("test polarity done");
    stop_test();
  end
endmodule
bind uafs_serial_port uafs_serial_port_asserts u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_transmit_line(serial_transmit_line), .irq(irq));
